// ### verilog/scp_pkg.sv
/*
  shared constants of the serial control port: register map, control fields,
  instruction layout and link timing.
  assumes both ends and the bench import it.
*/
package scp_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [12:0] SERIAL_PORT_CONFIG_ADDR = 13'h0000;
  localparam logic [12:0] READBACK_SOURCE_SELECT_ADDR = 13'h0001;
  localparam logic [12:0] CHIP_TYPE_ADDR = 13'h0003;
  localparam logic [12:0] PRODUCT_ID_ADDR = 13'h0004;
  localparam logic [12:0] BUFFER_TRANSFER_TRIGGER_ADDR = 13'h000F;
  localparam logic [7:0] SERIAL_PORT_CONFIG_RST = 8'h00;
  localparam logic [7:0] READBACK_SOURCE_SELECT_RST = 8'h00;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 7;
  localparam int LSB_FIRST_BIT = 6;
  localparam int ASCEND_BIT = 5;
  localparam int ASCEND_MIRROR_BIT = 2;
  localparam int FOUR_WIRE_BIT = 4;
  localparam int FOUR_WIRE_MIRROR_BIT = 3;
  localparam int READ_ACTIVE_BIT = 5;
  localparam int TRANSFER_BIT = 0;
  // ------------------------------------------------------------
  // instruction word
  // ------------------------------------------------------------
  localparam int INSTR_BITS = 16;
  localparam int RW_BIT = 15;
  localparam int ADDR_BITS = 13;
  localparam int BYTE_BITS = 8;
  // ------------------------------------------------------------
  // link timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_MAX_MHZ = 40;
  localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
  // least time, rounded up to whole clk cycles per half period
  localparam int SCLK_HALF_CYCLES =
    (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
endpackage : scp_pkg

// ### verilog/scp_link_if.sv
/*
  wires of the serial link between host and device.
  resolves the shared data pin from the enables itself, so the bench need not.
*/
`timescale 1ns/1ps
interface scp_link_if;
  logic cs_n;
  logic sclk;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic serial_output_data_pin_o;
  logic serial_output_data_pin_oe;
  logic sdio;
  logic serial_output_data_pin;
  // resolved levels, idle high like a pulled-up line
  assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);
  assign serial_output_data_pin =
    serial_output_data_pin_oe ? serial_output_data_pin_o : 1'b1;
  modport host_mp (
    output cs_n, sclk, sdio_host_o, sdio_host_oe,
    input sdio, serial_output_data_pin
  );
  modport dev_mp (
    input cs_n, sclk, sdio,
    output sdio_dev_o, sdio_dev_oe, serial_output_data_pin_o, serial_output_data_pin_oe
  );
endinterface : scp_link_if

// ### verilog/scp_device.sv
/*
  device end of the serial control port: instruction decode, streaming
  register access, buffered and active registers, soft reset.
  assumes the link clock stands still while chip select is high.
*/
// Summary of operation
// - sample on rising, launch on falling edge
// - host keeps serial clock at 40 MHz or less
// - 3-wire shares data pin, 4-wire separate output
// - unlimited streaming bytes, address steps per byte
// - host raises chip select after last byte
// - chip select high releases both data pins
// - 16-bit instruction on first 16 rising edges
// - MSB-first: first bit direction, next 15 bits address; LSB-first: address first, direction last
// - top two address bits ignored as zero
// - buffered writes idle until buffer transfer
// - transfer bit triggers copy, then self-clears
// - reads shift eight cycles per byte, no skips
// - host captures read bits on next rising edge
// - readback source bit picks buffer or active
// - LSB-first bit flips order from next operation (here from the next byte of the same frame)
// - ascend bit chooses increment, else decrement
// - address wraps between 0x1FFF and 0x0000
// - host writes defaults over reserved addresses
// - host writes zeros to blank registers
// - no single-byte instruction form
// - readable chip type and product identifier
// - soft reset clears both banks and its own bit after one more clock
`timescale 1ns/1ps
module scp_device #(
  parameter int NREG = 32,
  parameter logic [7:0] CHIP_TYPE = 8'h0C,  // arbitrary value
  parameter logic [7:0] PRODUCT_ID = 8'h2A  // arbitrary value
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  scp_link_if.dev_mp link,
  // active registers toward the core, clk domain
  output logic [NREG*8-1:0] active_regs,
  output logic update_pulse
);
  import scp_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // persistent registers, cleared by rst; soft reset also clears both banks
  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [NREG-1:0][7:0] bufr;
    logic [NREG-1:0][7:0] act;
    logic soft_pend;
    logic upd_tgl;
  } regs_t;
  // per-frame state, cleared while chip select is high
  typedef struct packed {
    logic [15:0] sr;
    logic [4:0] cnt;
    logic [2:0] bi;
    logic rd;
    logic [ADDR_BITS-1:0] addr;
  } frame_t;
  // core side crossing
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [NREG*8-1:0] act;
    logic pulse;
  } core_t;

  regs_t r_ff, nxt_r;
  frame_t f_ff, nxt_f;
  core_t c_ff, nxt_c;
  logic tx_ff, nxt_tx;
  logic oe_ff, nxt_oe;
  logic frame_rst;
  logic lsb;
  logic ascend;
  logic four_wire;
  logic [15:0] inb;
  logic [7:0] in_byte;
  logic [7:0] rbyte;
  logic driving;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // readback decode, shared by launch logic
  function automatic logic [7:0] read_reg(input regs_t r, input logic [ADDR_BITS-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      SERIAL_PORT_CONFIG_ADDR: v = r.cfg0;
      READBACK_SOURCE_SELECT_ADDR: v = r.cfg1;
      CHIP_TYPE_ADDR: v = CHIP_TYPE;
      PRODUCT_ID_ADDR: v = PRODUCT_ID;
      BUFFER_TRANSFER_TRIGGER_ADDR: v = 8'h00;  // transfer bit always reads back cleared
      // above the banks nothing is stored, so it reads zero
      default: v = (32'(a) < NREG) ? (r.cfg1[READ_ACTIVE_BIT] ? r.act[a] : r.bufr[a])
                                    : 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // frame state lives only while chip select is low
  assign frame_rst = rst | link.cs_n;
  assign lsb = r_ff.cfg0[LSB_FIRST_BIT];
  assign ascend = r_ff.cfg0[ASCEND_BIT] | r_ff.cfg0[ASCEND_MIRROR_BIT];
  assign four_wire = r_ff.cfg0[FOUR_WIRE_BIT] | r_ff.cfg0[FOUR_WIRE_MIRROR_BIT];
  // both orders land in the same layout: rw at bit 15, address below
  assign inb = lsb ? {link.sdio, f_ff.sr[15:1]} : {f_ff.sr[14:0], link.sdio};
  assign in_byte = lsb ? inb[15:8] : inb[7:0];
  assign rbyte = read_reg(r_ff, f_ff.addr);

  // ------------------------------------------------------------
  // rising-edge logic
  // ------------------------------------------------------------
  // instruction then payload; writes land when the eighth bit arrives
  always_comb
  begin
    nxt_r = r_ff;
    nxt_f = f_ff;
    nxt_f.sr = inb;
    if (r_ff.soft_pend)
    begin
      // one further clock after the request completes the reset
      nxt_r.bufr = {NREG{REG_DEFAULT}};
      nxt_r.act = {NREG{REG_DEFAULT}};
      nxt_r.cfg0[SOFT_RESET_BIT] = 1'b0;
      nxt_r.soft_pend = 1'b0;
      nxt_r.upd_tgl = ~r_ff.upd_tgl;
    end
    if (f_ff.cnt < 5'(INSTR_BITS))
    begin
      // no short instruction form: always a full word
      nxt_f.cnt = f_ff.cnt + 5'd1;
      if (f_ff.cnt == 5'(INSTR_BITS - 1))
      begin
        nxt_f.rd = inb[RW_BIT];
        nxt_f.addr = inb[ADDR_BITS-1:0];
        nxt_f.bi = 3'd0;
      end
    end
    else
    begin
      nxt_f.bi = f_ff.bi + 3'd1;
      if (f_ff.bi == 3'd7)
      begin
        // step once per byte, 13-bit wrap in both directions
        nxt_f.addr = ascend ? f_ff.addr + 13'd1 : f_ff.addr - 13'd1;
        if (!f_ff.rd)
        begin
          if (f_ff.addr == SERIAL_PORT_CONFIG_ADDR)
          begin
            nxt_r.cfg0 = in_byte;
            nxt_r.soft_pend = in_byte[SOFT_RESET_BIT];
          end
          else if (f_ff.addr == READBACK_SOURCE_SELECT_ADDR)
          begin
            nxt_r.cfg1 = in_byte;
          end
          else if (f_ff.addr == BUFFER_TRANSFER_TRIGGER_ADDR)
          begin
            // the bit is never stored, so it clears itself
            if (in_byte[TRANSFER_BIT])
            begin
              nxt_r.act = r_ff.bufr;
              nxt_r.upd_tgl = ~r_ff.upd_tgl;
            end
          end
          else if (f_ff.addr != CHIP_TYPE_ADDR && f_ff.addr != PRODUCT_ID_ADDR
                   && 32'(f_ff.addr) < NREG)
          begin
            nxt_r.bufr[f_ff.addr] = in_byte;
          end
        end
      end
    end
  end

  // persistent registers
  always_ff @(posedge link.sclk or posedge rst)
  begin
    if (rst)
    begin
      r_ff <= '0;
      r_ff.cfg0 <= SERIAL_PORT_CONFIG_RST;
      r_ff.cfg1 <= READBACK_SOURCE_SELECT_RST;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // frame registers
  always_ff @(posedge link.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      f_ff <= '0;
    end
    else
    begin
      f_ff <= nxt_f;
    end
  end

  // ------------------------------------------------------------
  // falling-edge launch
  // ------------------------------------------------------------
  // bit index counts bits already clocked in this byte
  always_comb
  begin
    nxt_tx = lsb ? rbyte[f_ff.bi] : rbyte[3'd7 - f_ff.bi];
    // enable only from the fall after the instruction, once the host let go
    nxt_oe = f_ff.rd & (f_ff.cnt == 5'(INSTR_BITS));
  end

  always_ff @(negedge link.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      tx_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      tx_ff <= nxt_tx;
      oe_ff <= nxt_oe;
    end
  end

  // pins released whenever chip select is high
  assign driving = ~link.cs_n & oe_ff;
  assign link.sdio_dev_o = tx_ff;
  assign link.sdio_dev_oe = driving & ~four_wire;
  assign link.serial_output_data_pin_o = tx_ff;
  assign link.serial_output_data_pin_oe = driving & four_wire;

  // ------------------------------------------------------------
  // core side crossing
  // ------------------------------------------------------------
  // toggle crossing; active bank only moves on a toggle, so it is stable
  // when sampled. two transfers closer than one clk cycle may cancel, leaving no pulse and no copy.
  always_comb
  begin
    nxt_c = c_ff;
    nxt_c.s1 = r_ff.upd_tgl;
    nxt_c.s2 = c_ff.s1;
    nxt_c.s3 = c_ff.s2;
    nxt_c.pulse = c_ff.s2 ^ c_ff.s3;
    nxt_c.act = (c_ff.s2 ^ c_ff.s3) ? r_ff.act : c_ff.act;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      c_ff <= '0;
    end
    else
    begin
      c_ff <= nxt_c;
    end
  end

  assign active_regs = c_ff.act;
  assign update_pulse = c_ff.pulse;
endmodule : scp_device

// ### verilog/scp_host.sv
/*
  host end of the serial control port: makes the link clock by division,
  sends instruction and payload, gathers read bytes.
  assumes its lsb_first and four_wire inputs match the device setting.
*/
`timescale 1ns/1ps
module scp_host #(
  parameter int HALF = scp_pkg::SCLK_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  scp_link_if.host_mp link,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_rw,
  input wire logic [scp_pkg::ADDR_BITS-1:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  // link format
  input wire logic lsb_first,
  input wire logic four_wire,
  // payload
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done
);
  import scp_pkg::*;

  typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, TAIL} st_t;
  typedef struct packed {
    st_t st;
    logic [7:0] div;
    logic [11:0] cnt;
    logic [11:0] nbits;
    logic [15:0] sh;
    logic [7:0] rsh;
    logic rd;
    logic lsb;
    logic fw;
    logic cs_n;
    logic sclk;
    logic dout;
    logic oe;
    logic s1a;
    logic s2a;
    logic s1b;
    logic s2b;
    logic take;
    logic [7:0] rdat;
    logic rvld;
    logic dn;
  } host_t;

  host_t s_ff, nxt_s;
  logic [15:0] tmp;
  logic pin;
  logic [7:0] rb;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // each bit: drive while low, sample at the rising tick
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.take = 1'b0;
    nxt_s.rvld = 1'b0;
    nxt_s.dn = 1'b0;
    nxt_s.s1a = link.sdio;
    nxt_s.s2a = s_ff.s1a;
    nxt_s.s1b = link.serial_output_data_pin;
    nxt_s.s2b = s_ff.s1b;
    tmp = s_ff.sh;
    pin = s_ff.fw ? s_ff.s2b : s_ff.s2a;
    rb = s_ff.lsb ? {pin, s_ff.rsh[7:1]} : {s_ff.rsh[6:0], pin};
    nxt_s.div = (s_ff.div == 8'd0) ? 8'd0 : s_ff.div - 8'd1;
    unique case (s_ff.st)
      IDLE:
      begin
        if (cmd_valid)
        begin
          nxt_s.sh = {cmd_rw, 2'b00, cmd_addr};
          nxt_s.rd = cmd_rw;
          nxt_s.lsb = lsb_first;
          nxt_s.fw = four_wire;
          nxt_s.nbits = 12'(INSTR_BITS) + {cmd_len, 3'b000};
          nxt_s.cnt = 12'd0;
          nxt_s.cs_n = 1'b0;
          nxt_s.div = 8'(HALF - 1);
          nxt_s.st = LEAD;
        end
      end
      LEAD, HIGH:
      begin
        if (s_ff.div == 8'd0)
        begin
          if (s_ff.st == HIGH && s_ff.cnt == s_ff.nbits)
          begin
            nxt_s.sclk = 1'b0;
            nxt_s.oe = 1'b0;
            nxt_s.div = 8'(HALF - 1);
            nxt_s.st = TAIL;
          end
          else
          begin
            if (s_ff.cnt >= 12'(INSTR_BITS) && s_ff.cnt[2:0] == 3'd0 && !s_ff.rd)
            begin
              tmp = {wr_data, wr_data};
              nxt_s.take = 1'b1;
            end
            nxt_s.dout = s_ff.lsb ? tmp[0] : tmp[15];
            nxt_s.sh = s_ff.lsb ? {1'b0, tmp[15:1]} : {tmp[14:0], 1'b0};
            // let go of the shared pin before the device launches
            nxt_s.oe = !(s_ff.rd && s_ff.cnt >= 12'(INSTR_BITS)) && !s_ff.fw
                       || !(s_ff.rd && s_ff.cnt >= 12'(INSTR_BITS));
            nxt_s.sclk = 1'b0;
            nxt_s.div = 8'(HALF - 1);
            nxt_s.st = LOW;
          end
        end
      end
      LOW:
      begin
        if (s_ff.div == 8'd0)
        begin
          // capture read data on the rising tick
          nxt_s.sclk = 1'b1;
          nxt_s.cnt = s_ff.cnt + 12'd1;
          if (s_ff.rd && s_ff.cnt >= 12'(INSTR_BITS))
          begin
            nxt_s.rsh = rb;
            if (s_ff.cnt[2:0] == 3'd7)
            begin
              nxt_s.rdat = rb;
              nxt_s.rvld = 1'b1;
            end
          end
          nxt_s.div = 8'(HALF - 1);
          nxt_s.st = HIGH;
        end
      end
      TAIL:
      begin
        if (s_ff.div == 8'd0)
        begin
          nxt_s.cs_n = 1'b1;
          nxt_s.dn = 1'b1;
          nxt_s.st = IDLE;
        end
      end
      default:
      begin
        nxt_s.st = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.st <= IDLE;
      s_ff.cs_n <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // half period of at least 12.5 ns keeps the clock within its limit
  assign link.sclk = s_ff.sclk;
  assign link.cs_n = s_ff.cs_n;
  assign link.sdio_host_o = s_ff.dout;
  assign link.sdio_host_oe = s_ff.oe;
  assign cmd_ready = (s_ff.st == IDLE);
  assign wr_take = s_ff.take;
  assign rd_data = s_ff.rdat;
  assign rd_valid = s_ff.rvld;
  assign done = s_ff.dn;
endmodule : scp_host

// ### sim/scp_link_sva.sv
/*
  link checks between host and device ends of the serial control port.
  assumes the bench wires it beside the link interface, in the clk domain.
*/
`timescale 1ns/1ps
module scp_link_sva (
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic serial_output_data_pin_oe
);
  typedef struct packed {logic sclk_q; logic [4:0] rises;} mon_t;
  mon_t mon_ff;
  mon_t nxt_mon;
  // ----------------------------------------
  // rise counter per frame, saturating
  // ----------------------------------------
  always_comb
  begin
    nxt_mon = mon_ff;
    nxt_mon.sclk_q = sclk;
    if (cs_n)
      nxt_mon.rises = 5'h00;
    else if (sclk && !mon_ff.sclk_q && mon_ff.rises != 5'h1f)
      nxt_mon.rises = mon_ff.rises + 5'h01;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mon_ff <= '0;
    else
      mon_ff <= nxt_mon;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_cs_pins_released: assert property (cs_n |-> !sdio_dev_oe && !serial_output_data_pin_oe)
    else $error("device drives a data pin while deselected");
  a_no_contention: assert property (!(sdio_host_oe && sdio_dev_oe))
    else $error("host and device drive the shared pin together");
  a_one_out_pin: assert property (!(sdio_dev_oe && serial_output_data_pin_oe))
    else $error("device drives both output pins");
  a_launch_on_fall: assert property (sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_o)
    |-> !sclk)
    else $error("read bit changed while link clock high");
  a_clock_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock high outside a frame");
  a_high_phase: assert property ($rose(sclk) |-> sclk[*3])
    else $error("link clock high phase too short");
  a_low_phase: assert property ($fell(sclk) |-> !sclk[*3])
    else $error("link clock low phase too short");
  a_cs_edges_low: assert property ($rose(cs_n) || $fell(cs_n) |-> !sclk)
    else $error("chip select moved with link clock high");
  a_read_after_instr: assert property (sdio_dev_oe || serial_output_data_pin_oe
    |-> mon_ff.rises >= 5'd16)
    else $error("device answered inside the instruction word");
endmodule : scp_link_sva

// ### sim/test_clock_chip_serial_control_port.sv
/*
  self-checking bench: host and device ends joined by the link interface.
  assumes the host walks the link; expectations come from a register model.
*/
`timescale 1ns/1ps
module test_clock_chip_serial_control_port;
  import scp_pkg::*;
  localparam logic [7:0] CHIP_ID = 8'h5a;  // arbitrary value
  localparam logic [7:0] PART_ID = 8'h3c;  // arbitrary value
  logic clk, rst, cmd_valid, cmd_rw, lsb_first, four_wire;
  logic [12:0] cmd_addr, wa;
  logic [7:0] cmd_len, wr_data, rd_data, cfg_m, sel_m;
  logic cmd_ready, wr_take, rd_valid, done, update_pulse;
  logic [255:0] active_regs;
  logic [7:0] wbuf [0:15];
  logic [7:0] buf_m [0:31];
  logic [7:0] act_m [0:31];
  logic [7:0] rq [$];
  logic [15:0] seed;
  int error_cnt, tests_run, upd_cnt, widx, u;
  scp_link_if scp_link_if_i ();
  scp_host scp_host_i (.clk(clk), .rst(rst), .link(scp_link_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .lsb_first(lsb_first), .four_wire(four_wire), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
  scp_device #(.NREG(32), .CHIP_TYPE(CHIP_ID), .PRODUCT_ID(PART_ID)) scp_device_i (.clk(clk),
    .rst(rst), .link(scp_link_if_i), .active_regs(active_regs), .update_pulse(update_pulse));
  scp_link_sva scp_link_sva_i (.clk(clk), .rst(rst), .cs_n(scp_link_if_i.cs_n),
    .sclk(scp_link_if_i.sclk), .sdio_host_oe(scp_link_if_i.sdio_host_oe),
    .sdio_dev_o(scp_link_if_i.sdio_dev_o), .sdio_dev_oe(scp_link_if_i.sdio_dev_oe),
    .serial_output_data_pin_oe(scp_link_if_i.serial_output_data_pin_oe));
  always #2.5 clk = ~clk;
  // ----------------------------------------
  // monitors and payload feed, off the sampling edge
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (update_pulse === 1'b1) upd_cnt++;
    if (wr_take === 1'b1)
    begin
      widx++;
      wr_data = wbuf[widx[3:0]];
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic is_buf(input logic [12:0] a);
    return a < 13'd32 && a != 13'h0 && a != 13'h1 && a != 13'h3 && a != 13'h4 && a != 13'hf;
  endfunction : is_buf
  // expected read byte; source chosen by the readback select model
  function automatic logic [7:0] rexp(input logic [12:0] a);
    if (a == 13'h0) return cfg_m;
    if (a == 13'h1) return sel_m;
    if (a == 13'h3) return CHIP_ID;
    if (a == 13'h4) return PART_ID;
    if (!is_buf(a)) return 8'h00;
    return sel_m[5] ? act_m[a[4:0]] : buf_m[a[4:0]];
  endfunction : rexp
  // 13-bit arithmetic gives the wrap at both ends
  function automatic logic [12:0] step(input logic [12:0] a);
    return (cfg_m[5] | cfg_m[2]) ? a + 13'h1 : a - 13'h1;
  endfunction : step
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wmodel(input logic [12:0] a, input logic [7:0] d);
    if (a == 13'h0) cfg_m = {1'b0, d[6:0]};
    if (a == 13'h1) sel_m = d;
    for (int i = 0; i < 32; i++)
    begin
      if (a == 13'h0 && d[7]) buf_m[i] = 8'h00;
      if (a == 13'h0 && d[7]) act_m[i] = 8'h00;
      if (a == 13'hf && d[0]) act_m[i] = buf_m[i];
    end
    if (is_buf(a)) buf_m[a[4:0]] = d;
  endtask : wmodel
  task automatic chk_active();
    for (int i = 0; i < 32; i++)
      if (is_buf(i[12:0])) chk("active byte", active_regs[8*i +: 8], act_m[i]);
  endtask : chk_active
  task automatic fill(input int n);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      wbuf[i] = seed[7:0];
    end
  endtask : fill
  // single configuration byte, always a one-byte write
  task automatic put_byte(input logic [12:0] addr, input logic [7:0] d);
    wbuf[0] = d;
    xfer(0, addr, 1);
  endtask : put_byte
  // one command; write payload comes from wbuf, read bytes land in rq
  task automatic xfer(input logic rw, input logic [12:0] addr, input int len);
    logic [12:0] a;
    rq.delete();
    widx = 0;
    wr_data = wbuf[0];
    cmd_rw = rw;
    cmd_addr = addr;
    cmd_len = len[7:0];
    chk("ready when idle", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("ready while busy", cmd_ready, 1'b0);
    while (done !== 1'b1) @(negedge clk);
    a = addr;
    for (int i = 0; i < len; i++)
    begin
      if (rw) chk("read byte", rq[i], rexp(a));
      else wmodel(a, wbuf[i]);
      a = step(a);
    end
    if (rw) chk("read count", rq.size(), len[7:0]);
    repeat (10) @(negedge clk);
  endtask : xfer
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_rw = 1'b0;
    cmd_addr = 13'h0000;
    cmd_len = 8'h01;
    lsb_first = 1'b0;
    four_wire = 1'b0;
    wr_data = 8'h00;
    error_cnt = 0;
    tests_run = 0;
    upd_cnt = 0;
    widx = 0;
    seed = 16'h4e84;
    cfg_m = 8'h00;
    sel_m = 8'h00;
    for (int i = 0; i < 32; i++)
    begin
      buf_m[i] = 8'h00;
      act_m[i] = 8'h00;
    end
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_active();
    put_byte(13'h0000, 8'h24);
    fill(8);
    xfer(0, 13'h0010, 8);
    chk_active();
    xfer(1, 13'h0010, 8);
    put_byte(13'h0001, 8'h20);
    xfer(1, 13'h0010, 8);
    u = upd_cnt;
    put_byte(13'h000f, 8'h01);
    chk("update pulses", upd_cnt - u, 8'h01);
    chk_active();
    xfer(1, 13'h000e, 4);
    xfer(1, 13'h1ffe, 4);
    xfer(1, 13'h0003, 2);
    put_byte(13'h0000, 8'h00);
    xfer(1, 13'h0002, 4);
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      u = 1 + seed[10:8];
      // either direction bit alone must turn the stream upward
      put_byte(13'h0000, {2'b00, seed[12], 2'b00, seed[13], 2'b00});
      cmd_addr = 13'h0010 + seed[3:0];
      fill(u);
      wa = cmd_addr;
      for (int j = 0; j < u; j++)
      begin
        // nothing lives above the banks, so only zeros go there
        if (wa > 13'h001f) wbuf[j] = 8'h00;
        wa = step(wa);
      end
      xfer(0, cmd_addr, u);
      xfer(1, cmd_addr, u);
      chk_active();
    end
    put_byte(13'h0000, 8'h66);
    lsb_first = 1'b1;
    fill(2);
    xfer(0, 13'h0014, 2);
    xfer(1, 13'h0010, 8);
    // four-wire through the mirror bit alone
    put_byte(13'h0000, 8'h6e);
    four_wire = 1'b1;
    xfer(1, 13'h0010, 8);
    put_byte(13'h0000, 8'hfe);
    xfer(1, 13'h0010, 8);
    chk_active();
    test_done();
  end
endmodule : test_clock_chip_serial_control_port
